// ### bench/rts_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Pin driver, supply monitor and both oscillators
module rts_partner (
	input wire logic pin_low_i, // Hold reset pin low
	input wire logic supply_i, // Supply is up
	input wire logic bo_i, // Supply is low
	output logic pin_o, // Reset pin level
	output logic sup_o, // Supply-rise detector
	output logic bo_o, // Brown-out detector
	output logic rc_o, // Internal RC oscillator
	output logic osc_o // Primary oscillator
);
	initial begin
		rc_o = 1'b0;
		osc_o = 1'b0;
	end
	// Pin has a pull-up, so released means high
	assign pin_o = ~pin_low_i;
	assign sup_o = supply_i;
	assign bo_o = bo_i;
	// RC well below sys_clk/2 so every tick is seen
	always #20 rc_o = ~rc_o;
	always #10 osc_o = ~osc_o;
endmodule
`default_nettype wire

// ### bench/test_rts_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_rts_sequencer;
	import rts_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic pin_low = 1'b0;
	logic supply = 1'b1;
	logic bo = 1'b0;
	logic be = 1'b1;
	logic slp = 1'b0;
	logic [6:0] ev = '0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic pin, sup, bo_w, rc, osc, pin_d, pin_oe, crst, hold, ldef, resume;
	rts_src_type src;
	int error_cnt = 0;
	int compares = 0;
	logic pde = 1'b0;
	logic pll_en = 1'b1;
	rts_osc_type mode = OSC_HS;
	always #2 clk = ~clk;
	rts_partner i_rts_partner (.pin_low_i(pin_low), .supply_i(supply), .bo_i(bo),
		.pin_o(pin), .sup_o(sup), .bo_o(bo_w), .rc_o(rc), .osc_o(osc));
	rts_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(20), .PLL_CYCLES(8), .OST_CYCLES(16), .FILT_CYCLES(4))
	i_rts_sequencer (.sys_clk_i(clk), .arst_n_i(rst_n), .supply_rise_i(sup),
		.external_reset_pin_i(pin), .external_reset_pin_o(pin_d),
		.external_reset_pin_oe_o(pin_oe), .brownout_detect_i(bo_w), .rc_osc_i(rc),
		.osc_clk_i(osc), .brownout_enable_bit_i(be), .powerup_delay_enable_i(pde),
		.pll_enable_i(pll_en), .osc_mode_i(mode), .sleep_i(slp),
		.watchdog_expire_i(ev[0]), .reset_instr_i(ev[1]), .stack_full_i(ev[2]),
		.stack_underflow_i(ev[3]), .irq_wake_i(ev[4]), .osc_switch_i(ev[5]),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.chip_reset_o(crst), .core_hold_o(hold), .load_defaults_o(ldef),
		.resume_next_o(resume), .reset_source_o(src));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask
	task automatic conclude();
		$display("mismatches=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev <= '0;
		#1;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Bounded wait for release of the chip reset
	task automatic wait_rel();
		int n;
		n = 0;
		while (crst !== 1'b0 && n < 3000) begin
			cyc(1);
			n++;
		end
		chk({7'h0, crst}, 8'h00);
	endtask
	task automatic wait_resume();
		int n;
		n = 0;
		while (resume !== 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
		chk({6'h0, resume, hold}, 8'h02);
	endtask
	task automatic src_is(input logic [3:0] s);
		chk({4'h0, src}, {4'h0, s});
	endtask
	initial begin
		#200000;
		error_cnt++;
		conclude();
	end
	initial begin
		cyc(4);
		rst_n <= 1'b1;
		rreg(4'h0, 8'h1C);
		chk({7'h0, crst}, 8'h01);
		wait_rel();
		src_is(4'h1);
		rreg(4'h5, 8'h00);
		wreg(4'h5, 8'hFF);
		rreg(4'h0, 8'h1C);
		wreg(4'h0, 8'hFF);
		rreg(4'h0, 8'hDF);
		wreg(4'h0, 8'h1F);
		pulse(1);
		chk({5'h0, crst, ldef, hold}, 8'h07);
		src_is(4'h6);
		wait_rel();
		rreg(4'h0, 8'h0F);
		pulse(2);
		src_is(4'h7);
		wait_rel();
		pulse(3);
		src_is(4'h8);
		wait_rel();
		rreg(4'h0, 8'h0F);
		pulse(0);
		src_is(4'h4);
		wait_rel();
		rreg(4'h0, 8'h07);
		// Short glitch on the pin must be swallowed
		@(posedge clk);
		pin_low <= 1'b1;
		@(posedge clk);
		pin_low <= 1'b0;
		cyc(20);
		chk({7'h0, crst}, 8'h00);
		@(posedge clk);
		pin_low <= 1'b1;
		cyc(20);
		chk({5'h0, crst, pin_d, pin_oe}, 8'h04);
		src_is(4'h2);
		@(posedge clk);
		pin_low <= 1'b0;
		wait_rel();
		rreg(4'h0, 8'h07);
		be <= 1'b0;
		bo <= 1'b1;
		cyc(20);
		chk({7'h0, crst}, 8'h00);
		bo <= 1'b0;
		cyc(10);
		be <= 1'b1;
		bo <= 1'b1;
		cyc(60);
		chk({7'h0, crst}, 8'h01);
		src_is(4'h5);
		rreg(4'h1, 8'hD1);
		bo <= 1'b0;
		cyc(60);
		bo <= 1'b1;
		cyc(10);
		bo <= 1'b0;
		// Without a restart the delay would already be over by now
		cyc(150);
		chk({7'h0, crst}, 8'h01);
		rreg(4'h1, 8'h92);
		wait_rel();
		rreg(4'h0, 8'h1E);
		slp <= 1'b1;
		pulse(0);
		chk({6'h0, crst, hold}, 8'h01);
		src_is(4'h9);
		wait_resume();
		slp <= 1'b0;
		rreg(4'h0, 8'h12);
		slp <= 1'b1;
		pulse(4);
		src_is(4'hA);
		wait_resume();
		slp <= 1'b0;
		rreg(4'h0, 8'h1A);
		pll_en <= 1'b0;
		pulse(5);
		chk({6'h0, crst, hold}, 8'h01);
		wait_resume();
		pll_en <= 1'b1;
		wreg(4'h0, 8'h16);
		slp <= 1'b1;
		pin_low <= 1'b1;
		cyc(20);
		src_is(4'h3);
		slp <= 1'b0;
		pin_low <= 1'b0;
		wait_rel();
		rreg(4'h0, 8'h1A);
		// Second power-on: RC mode with the delay skipped has no time-out
		@(posedge clk);
		rst_n <= 1'b0;
		pde <= 1'b1;
		mode <= OSC_RC;
		cyc(4);
		rst_n <= 1'b1;
		cyc(3);
		chk({7'h0, crst}, 8'h01);
		cyc(20);
		chk({7'h0, crst}, 8'h00);
		src_is(4'h1);
		rreg(4'h0, 8'h1C);
		slp <= 1'b1;
		pulse(0);
		chk({6'h0, crst, hold}, 8'h00);
		src_is(4'h9);
		slp <= 1'b0;
		rreg(4'h0, 8'h10);
		conclude();
	end
endmodule
`default_nettype wire

// ### verilog/rts_pkg.sv
package rts_pkg;

	// System clock
	localparam int SYS_PERIOD_NS = 4;

	// External pin filter: pulses shorter than this are ignored
	localparam int FILT_NS = 200;
	localparam int FILT_CYC = (FILT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int FILT_W = $clog2(FILT_CYC + 1);

	// Internal RC oscillator tick period, nominal
	localparam int RC_TICK_NS = 1000;
	// Power-up delay and PLL lock wait, counted in RC ticks
	localparam int POWERUP_DELAY_TIMER_US = 72000;
	localparam int PLL_US = 2000;
	localparam int POWERUP_DELAY_TIMER_CYC = POWERUP_DELAY_TIMER_US * 1000 / RC_TICK_NS;
	localparam int PLL_CYC = PLL_US * 1000 / RC_TICK_NS;
	// Crystal start-up, counted in primary oscillator cycles
	localparam int OST_CYC = 1024;
	localparam int CNT_W = 17;

	// Register map
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CAUSE_ADDR = 4'h0;
	localparam logic [3:0] REG_SEQ_ADDR = 4'h1;

	// Reset cause register fields
	localparam int BIT_BOR = 0;
	localparam int BIT_POR = 1;
	localparam int BIT_PD = 2;
	localparam int BIT_TO = 3;
	localparam int BIT_RI = 4;
	localparam int BIT_LONG_WRITE_ENABLE = 6;
	localparam int BIT_PRIORITY_ENABLE = 7;
	localparam logic [7:0] CAUSE_RST = 8'h1C;
	localparam logic [7:0] CAUSE_WMASK = 8'hDF;

	// Async input positions in the synchroniser vector
	localparam int AIN_SUP = 0;
	localparam int AIN_PIN = 1;
	localparam int AIN_BO = 2;
	localparam int AIN_RC = 3;
	localparam int AIN_OSC = 4;
	localparam int AIN_N = 5;

	typedef enum logic [2:0] {
		OSC_LP = 3'h0,
		OSC_XT = 3'h1,
		OSC_HS = 3'h2,
		OSC_EC = 3'h3,
		OSC_RC = 3'h4
	} rts_osc_type;

	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_BROWN = 3'h1,
		ST_POWERUP_DELAY_TIMER = 3'h2,
		ST_OST = 3'h3,
		ST_PLL = 3'h4,
		ST_HOLD = 3'h5,
		ST_POR = 3'h6
	} rts_state_type;

	typedef enum logic [3:0] {
		SRC_NONE = 4'h0,
		SRC_POR = 4'h1,
		SRC_PIN_RUN = 4'h2,
		SRC_PIN_SLEEP = 4'h3,
		SRC_WDT = 4'h4,
		SRC_BOR = 4'h5,
		SRC_INSTR = 4'h6,
		SRC_STK_FULL = 4'h7,
		SRC_STK_UNF = 4'h8,
		SRC_WDT_WAKE = 4'h9,
		SRC_IRQ_WAKE = 4'hA
	} rts_src_type;

endpackage

// ### verilog/rts_sequencer.sv
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Eight reset sources are told apart.
// - Plain registers untouched except at power-on.
// - Listed resets load defined reset states.
// - Watchdog wake resumes, leaving registers alone.
// - Short pulses on the reset pin are filtered.
// - Reset pin is never driven by us.
// - Supply-rise pulse starts the time-out chain.
// - Power-up delay on RC clock after power-on/brown-out.
// - Enable bit zero runs delay, one skips it at power-on; brown-out always runs it.
// - Crystal start-up holds 1024 oscillator cycles.
// - Start-up count only crystal modes: power-on, brown-out, wake, oscillator switch.
// - High-speed PLL adds lock wait after start-up.
// - Lock wait also after wake and oscillator switch.
// - Brown-out enable bit gates brown-out reset.
// - Brown-out holds reset, then power-up delay.
// - Brown-out during delay restarts the delay.
// - Order: power-on, delay, start-up; skip inapplicable.
// - Time-outs ignore pin; late release runs at once.
// - Clock and RC modes: delay only at power-up.
// - Cause register bit layout fixed, bit5 reads zero.
// - Each source updates cause flags its own way.
// - Power-on sets three flags, clears two.
// - Reset instruction clears only its flag.
// - Wake clears sleep flag; watchdog wake clears expiry.
// - Pin reset in sleep sets expiry, clears sleep.
module rts_sequencer #(
	parameter int POWERUP_DELAY_TIMER_CYCLES = rts_pkg::POWERUP_DELAY_TIMER_CYC, // RC ticks
	parameter int PLL_CYCLES = rts_pkg::PLL_CYC, // RC ticks
	parameter int OST_CYCLES = rts_pkg::OST_CYC, // Oscillator cycles
	parameter int FILT_CYCLES = rts_pkg::FILT_CYC // System clocks
) (
	input wire logic sys_clk_i, // System clock
	input wire logic arst_n_i, // Async reset
	input wire logic supply_rise_i, // Supply-rise detector, async
	input wire logic external_reset_pin_i, // Reset pin level, async, low active
	output logic external_reset_pin_o, // Reset pin drive value
	output logic external_reset_pin_oe_o, // Reset pin drive enable
	input wire logic brownout_detect_i, // Supply-low detector, async
	input wire logic rc_osc_i, // Internal RC oscillator, async
	input wire logic osc_clk_i, // Primary oscillator input, async
	input wire logic brownout_enable_bit_i, // Config: brown-out on
	input wire logic powerup_delay_enable_i, // Config: 0 runs delay
	input wire logic pll_enable_i, // Config: 4x PLL on
	input wire rts_pkg::rts_osc_type osc_mode_i, // Config: oscillator mode
	input wire logic sleep_i, // Core is sleeping
	input wire logic watchdog_expire_i, // Watchdog expiry pulse
	input wire logic reset_instr_i, // Reset instruction pulse
	input wire logic stack_full_i, // Stack full reset pulse
	input wire logic stack_underflow_i, // Stack underflow reset pulse
	input wire logic irq_wake_i, // Interrupt wake pulse
	input wire logic osc_switch_i, // Switch to primary oscillator pulse
	input wire logic [rts_pkg::ADDR_W-1:0] addr_i, // Register address
	input wire logic [7:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [7:0] rdata_o, // Read data, cycle after strobe
	output logic chip_reset_o, // Device held in reset
	output logic core_hold_o, // Core stalled (reset or wake wait)
	output logic load_defaults_o, // Pulse: load defined reset states
	output logic resume_next_o, // Pulse: wake done in crystal modes (after start-up wait), resume
	output rts_pkg::rts_src_type reset_source_o // Last reset or wake source
);
	import rts_pkg::*;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	// Two-flop synchronisers, then an edge flop fed from stage two only
	logic [AIN_N-1:0] sync1;
	logic [AIN_N-1:0] sync2;
	logic [AIN_N-1:0] sync_d;
	wire [AIN_N-1:0] async_in = {osc_clk_i, rc_osc_i, brownout_detect_i,
		external_reset_pin_i, supply_rise_i};

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1 <= '0;
			sync2 <= '0;
			sync_d <= '0;
		end else begin
			sync1 <= async_in;
			sync2 <= sync1;
			sync_d <= sync2;
		end
	end

	wire por_pulse = sync2[AIN_SUP] & ~sync_d[AIN_SUP];
	wire rc_tick = sync2[AIN_RC] & ~sync_d[AIN_RC];
	wire osc_tick = sync2[AIN_OSC] & ~sync_d[AIN_OSC];
	wire bo_active = brownout_enable_bit_i & sync2[AIN_BO];

	// Pin filter: level must hold FILT_CYCLES clocks to be accepted
	// Sized from the parameter so a shortened or longer filter still fits
	localparam int FW = $clog2(FILT_CYCLES + 1);
	logic pin_filt;
	logic [FW-1:0] fcnt;
	wire pin_diff = sync2[AIN_PIN] != pin_filt;
	wire filt_commit = pin_diff && (fcnt == FW'(FILT_CYCLES - 1));
	wire pin_fall = filt_commit & ~sync2[AIN_PIN];

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_filt <= 1'b0;
			fcnt <= '0;
		end else begin
			if (filt_commit) begin
				pin_filt <= sync2[AIN_PIN];
			end
			fcnt <= (pin_diff && !filt_commit) ? fcnt + 1'b1 : '0;
		end
	end

	// Pin is input only; we never pull it
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			external_reset_pin_o <= 1'b0;
			external_reset_pin_oe_o <= 1'b0;
		end else begin
			external_reset_pin_o <= 1'b0;
			external_reset_pin_oe_o <= 1'b0;
		end
	end

	rts_state_type state;
	rts_state_type next_state;
	logic wake_seq;
	logic next_wake_seq;
	logic [CNT_W-1:0] cnt;
	logic [7:0] cause;
	logic [7:0] next_cause;

	wire in_run = state == ST_RUN;
	wire crystal = (osc_mode_i == OSC_LP) || (osc_mode_i == OSC_XT)
		|| (osc_mode_i == OSC_HS);
	wire hs_pll = (osc_mode_i == OSC_HS) && pll_enable_i;
	wire powerup_delay_timer_on = !powerup_delay_enable_i;

	// Source decode, highest priority first
	wire wdt_in = in_run & watchdog_expire_i;
	wire irq_wake = in_run & sleep_i & irq_wake_i;
	rts_src_type src;
	assign src = por_pulse ? SRC_POR :
		(bo_active && state != ST_BROWN) ? SRC_BOR :
		(in_run && pin_fall && sleep_i) ? SRC_PIN_SLEEP :
		(in_run && pin_fall) ? SRC_PIN_RUN :
		(wdt_in && sleep_i) ? SRC_WDT_WAKE :
		wdt_in ? SRC_WDT :
		(in_run && reset_instr_i) ? SRC_INSTR :
		(in_run && stack_full_i) ? SRC_STK_FULL :
		(in_run && stack_underflow_i) ? SRC_STK_UNF :
		irq_wake ? SRC_IRQ_WAKE : SRC_NONE;

	wire is_wake = (src == SRC_WDT_WAKE) || (src == SRC_IRQ_WAKE);
	wire switch_req = in_run && !sleep_i && osc_switch_i && src == SRC_NONE;

	// Stage length and the clock it counts
	wire [CNT_W-1:0] stage_last = (state == ST_POWERUP_DELAY_TIMER) ? CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1) :
		(state == ST_PLL) ? CNT_W'(PLL_CYCLES - 1) : CNT_W'(OST_CYCLES - 1);
	wire stage_tick = (state == ST_OST) ? osc_tick : rc_tick;
	wire stage_done = stage_tick && (cnt == stage_last);

	// Where each stage goes once it finishes
	wire crystal_pll = crystal & hs_pll;
	rts_state_type after_powerup_delay_timer;
	rts_state_type after_ost;
	rts_state_type after_wait;
	rts_state_type wake_entry;
	assign after_wait = wake_seq ? ST_RUN : ST_HOLD;
	assign after_powerup_delay_timer = crystal ? ST_OST : ST_HOLD;
	assign after_ost = crystal_pll ? ST_PLL : after_wait;
	assign wake_entry = crystal ? ST_OST : ST_RUN;

	always_comb begin
		next_state = state;
		next_wake_seq = wake_seq;
		if (src == SRC_POR) begin
			next_state = ST_POR;
			next_wake_seq = 1'b0;
		end else if (src == SRC_BOR) begin
			next_state = ST_BROWN;
			next_wake_seq = 1'b0;
		end else begin
			case (state)
				ST_POR: begin
					next_state = powerup_delay_timer_on ? ST_POWERUP_DELAY_TIMER : after_powerup_delay_timer;
				end
				ST_BROWN: begin
					if (!bo_active) begin
						next_state = ST_POWERUP_DELAY_TIMER;
					end
				end
				ST_POWERUP_DELAY_TIMER: begin
					if (stage_done) begin
						next_state = after_powerup_delay_timer;
					end
				end
				ST_OST: begin
					if (stage_done) begin
						next_state = after_ost;
					end
				end
				ST_PLL: begin
					if (stage_done) begin
						next_state = after_wait;
					end
				end
				ST_HOLD: begin
					if (pin_filt) begin
						next_state = ST_RUN;
					end
				end
				ST_RUN: begin
					if (src == SRC_PIN_SLEEP) begin
						next_state = wake_entry;
						next_wake_seq = 1'b0;
						if (wake_entry == ST_RUN) begin
							next_state = ST_HOLD;
						end
					end else if (is_wake || switch_req) begin
						next_state = wake_entry;
						next_wake_seq = 1'b1;
					end else if (src != SRC_NONE) begin
						next_state = ST_HOLD;
						next_wake_seq = 1'b0;
					end
				end
				default: begin
					next_state = ST_POR;
					next_wake_seq = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= ST_POR;
			wake_seq <= 1'b0;
			cnt <= '0;
		end else begin
			state <= next_state;
			wake_seq <= next_wake_seq;
			// Any stage change, a brown-out included, restarts the count
			if (next_state != state) begin
				cnt <= '0;
			end else if (stage_tick && (state == ST_POWERUP_DELAY_TIMER || state == ST_OST
				|| state == ST_PLL)) begin
				cnt <= cnt + 1'b1;
			end
		end
	end

	// Cause flags: a write lands first, the hardware event wins over it
	wire [7:0] sw_cause = wr_i && addr_i == REG_CAUSE_ADDR ?
		(cause & ~CAUSE_WMASK) | (wdata_i & CAUSE_WMASK) : cause;

	always_comb begin
		next_cause = sw_cause;
		case (src)
			SRC_POR: begin
				next_cause = CAUSE_RST;
			end
			SRC_PIN_RUN: begin
				next_cause[BIT_PRIORITY_ENABLE] = 1'b0;
				next_cause[BIT_LONG_WRITE_ENABLE] = 1'b0;
			end
			SRC_INSTR: begin
				next_cause[BIT_PRIORITY_ENABLE] = 1'b0;
				next_cause[BIT_RI] = 1'b0;
			end
			SRC_STK_FULL, SRC_STK_UNF: begin
				next_cause[BIT_PRIORITY_ENABLE] = 1'b0;
			end
			SRC_PIN_SLEEP: begin
				next_cause[BIT_PRIORITY_ENABLE] = 1'b0;
				next_cause[BIT_LONG_WRITE_ENABLE] = 1'b0;
				next_cause[BIT_TO] = 1'b1;
				next_cause[BIT_PD] = 1'b0;
			end
			SRC_WDT: begin
				next_cause[BIT_PRIORITY_ENABLE] = 1'b0;
				next_cause[BIT_TO] = 1'b0;
				next_cause[BIT_PD] = 1'b1;
			end
			SRC_WDT_WAKE: begin
				next_cause[BIT_TO] = 1'b0;
				next_cause[BIT_PD] = 1'b0;
			end
			SRC_IRQ_WAKE: begin
				next_cause[BIT_TO] = 1'b1;
				next_cause[BIT_PD] = 1'b0;
			end
			SRC_BOR: begin
				next_cause[BIT_PRIORITY_ENABLE] = 1'b0;
				next_cause[BIT_RI] = 1'b1;
				next_cause[BIT_TO] = 1'b1;
				next_cause[BIT_PD] = 1'b1;
				next_cause[BIT_BOR] = 1'b0;
			end
			default: begin
				next_cause = sw_cause;
			end
		endcase
		next_cause[5] = 1'b0;
	end

	// Only defined-state registers are reloaded; plain ones keep contents
	wire default_src = src != SRC_NONE && !is_wake;
	wire wake_done = wake_seq && state != ST_RUN && next_state == ST_RUN;
	wire [7:0] seq_status = {pin_filt, bo_active, wake_seq, chip_reset_o,
		1'b0, state};
	wire [7:0] rd_mux = (addr_i == REG_CAUSE_ADDR) ? cause :
		(addr_i == REG_SEQ_ADDR) ? seq_status : 8'h00;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cause <= CAUSE_RST;
			chip_reset_o <= 1'b1;
			core_hold_o <= 1'b1;
			load_defaults_o <= 1'b1;
			resume_next_o <= 1'b0;
			reset_source_o <= SRC_POR;
			rdata_o <= 8'h00;
		end else begin
			cause <= next_cause;
			chip_reset_o <= next_state != ST_RUN && !next_wake_seq;
			core_hold_o <= next_state != ST_RUN;
			load_defaults_o <= default_src;
			resume_next_o <= wake_done;
			if (src != SRC_NONE) begin
				reset_source_o <= src;
			end
			rdata_o <= rd_i ? rd_mux : 8'h00;
		end
	end

	a_pin_not_driven: assert property (
		!external_reset_pin_oe_o) else $error("reset pin driven");

	a_por_flag_set: assert property (
		src == SRC_POR |=> cause[4:0] == 5'h1C) else $error("power-on flags wrong");

	a_instr_clears_ri: assert property (
		src == SRC_INSTR |=> !cause[BIT_RI] && cause[3:0] == $past(sw_cause[3:0]))
		else $error("instruction reset flags wrong");

	a_wdt_wake_flags: assert property (
		src == SRC_WDT_WAKE |=> !cause[BIT_TO] && !cause[BIT_PD] && !chip_reset_o)
		else $error("watchdog wake flags wrong");

	a_pin_sleep_flags: assert property (
		src == SRC_PIN_SLEEP |=> cause[BIT_TO] && !cause[BIT_PD] && chip_reset_o)
		else $error("sleep pin reset flags wrong");

	a_brownout_holds: assert property (
		bo_active |=> chip_reset_o && state == ST_BROWN)
		else $error("brown-out did not hold reset");

	a_release_pin_high: assert property (
		$fell(chip_reset_o) |-> $past(pin_filt) && $past(state) == ST_HOLD)
		else $error("reset released with pin low");

	a_ost_full_count: assert property (
		state == ST_OST && next_state == after_ost && src == SRC_NONE
		|-> cnt == CNT_W'(OST_CYCLES - 1) && osc_tick)
		else $error("start-up count ended early");

	a_delay_skipped: assert property (
		state == ST_POR && powerup_delay_enable_i && src == SRC_NONE
		|=> state != ST_POWERUP_DELAY_TIMER) else $error("disabled delay ran");

	a_bor_gated: assert property (
		!brownout_enable_bit_i |-> src != SRC_BOR)
		else $error("brown-out while disabled");

	a_filter_rejects: assert property (
		$fell(pin_filt) |-> $past(sync2[AIN_PIN], 2) == 1'b0)
		else $error("pin filter passed short pulse");

endmodule
`default_nettype wire
